// *** dv/seq_operator_model.sv ***
// Far-side model: compile engine answer and stop-phase completion
`timescale 1ns/100ps
module seq_operator_model (
    input wire logic i_clk,
    input wire logic i_compile_req,
    input wire logic i_stop_req,
    input wire logic i_fail,
    output logic o_compile_done,
    output logic o_compile_ok,
    output logic o_stop_wait_done
);
    logic [2:0] creq_dly = 3'h0;
    logic [3:0] sreq_dly = 4'h0;
    initial {o_compile_done, o_compile_ok, o_stop_wait_done} = 3'h2;
    // Verdict is only valid with done; elsewhere it shows the wrong answer on purpose
    always @(negedge i_clk) begin
        creq_dly <= {creq_dly[1:0], i_compile_req};
        sreq_dly <= {sreq_dly[2:0], i_stop_req};
        o_compile_done <= creq_dly[2];
        o_compile_ok <= creq_dly[2] ? !i_fail : i_fail;
        o_stop_wait_done <= sreq_dly[3];
    end
endmodule // seq_operator_model

// *** dv/sequence_run_controller_chk.sv ***
// Assertion checker for the sequence run controller
`timescale 1ns/100ps
`include "seq_ctrl_defines.vh"
module sequence_run_controller_chk (
    input wire i_clk, i_rst_n, i_ce, i_leave_seq_mode, i_compile_cmd, i_compile_done,
    input wire i_compile_ok, i_start_cmd, i_hold_cmd, i_stop_cmd, i_abort_now_command,
    input wire i_resume_cmd, i_edit_cmd,
    input wire i_event_jump_command, i_run_step_event_en,
    input wire [2:0] o_state,
    input wire o_executable, o_compile_req, o_compile_error, o_run_enable,
    input wire o_output_freeze, o_stop_req, o_jump_req, o_keep_dest_numbers
);
    wire go = i_ce && !i_leave_seq_mode;
    wire act = (o_state == `ST_RUN) || (o_state == `ST_HOLD);
    wire quiet = !i_stop_cmd && !i_abort_now_command;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    compile_go_a: assert property (o_state == `ST_EDIT && go && i_compile_cmd |=>
        o_state == `ST_COMPILE && o_compile_req) else $error("compile not taken");
    compile_pass_a: assert property (o_state == `ST_COMPILE && go && i_compile_done &&
        i_compile_ok |=> o_state == `ST_READY && o_executable) else $error("no ready");
    compile_fail_a: assert property (o_state == `ST_COMPILE && go && i_compile_done &&
        !i_compile_ok |=> o_compile_error && !o_executable) else $error("no error flag");
    edit_stays_a: assert property (o_state == `ST_EDIT && !i_compile_cmd &&
        !i_leave_seq_mode |=> o_state == `ST_EDIT && !o_executable) else $error("left edit");
    start_run_a: assert property (o_state == `ST_READY && go && i_start_cmd |=>
        o_state == `ST_RUN && o_run_enable) else $error("start not taken");
    hold_freeze_a: assert property (o_state == `ST_RUN && go && i_hold_cmd && quiet |=>
        o_state == `ST_HOLD && o_output_freeze) else $error("hold not taken");
    stop_pulse_a: assert property (act && go && i_stop_cmd && !i_abort_now_command |=>
        o_state == `ST_STOPPING && o_stop_req ##1 !o_stop_req) else $error("stop wrong");
    abort_now_a: assert property ((act || o_state == `ST_STOPPING) && go &&
        i_abort_now_command |=> o_state == `ST_READY) else $error("abort not direct");
    jump_gate_a: assert property (o_jump_req |->
        $past(i_run_step_event_en && i_event_jump_command)) else $error("jump not enabled");
    keep_dest_a: assert property (o_keep_dest_numbers) else $error("dest renumbered");
    leave_osc_a: assert property (i_leave_seq_mode && i_ce |=>
        o_state == `ST_OSC) else $error("mode not left");
    resume_run_a: assert property (o_state == `ST_HOLD && go && i_resume_cmd &&
        quiet |=> o_state == `ST_RUN && !o_output_freeze) else $error("resume not taken");
    edit_again_a: assert property (o_state == `ST_READY && go && i_edit_cmd &&
        !i_start_cmd |=> o_state == `ST_EDIT && !o_executable) else $error("edit not taken");
endmodule // sequence_run_controller_chk
bind sequence_run_controller sequence_run_controller_chk chk_i (.i_clk, .i_rst_n, .i_ce,
    .i_leave_seq_mode, .i_compile_cmd, .i_compile_done, .i_compile_ok, .i_start_cmd,
    .i_hold_cmd, .i_stop_cmd, .i_abort_now_command, .i_resume_cmd, .i_edit_cmd,
    .i_event_jump_command,
    .i_run_step_event_en, .o_state, .o_executable, .o_compile_req, .o_compile_error,
    .o_run_enable, .o_output_freeze, .o_stop_req, .o_jump_req, .o_keep_dest_numbers);

// *** dv/tb.sv ***
// Testbench for the sequence run controller
`timescale 1ns/100ps
`include "seq_ctrl_defines.vh"
module tb;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, fail = 1'b0, ev_en = 1'b0;
    logic [17:0] cmd = 18'h0_0000;
    logic [7:0] edit_step = 8'h05, dest = 8'h07, run_step = 8'h03, side_q, jdest, ostep;
    logic done, ok, wdone, creq, sreq, frz, runen, jreq, cerr, exe, keep, seqm;
    logic [2:0] o_state;
    int bad_count = 0, total_checks = 0;
    sequence_run_controller sequence_run_controller_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_ce(i_ce), .i_enter_seq_mode(cmd[0]), .i_leave_seq_mode(cmd[1]),
        .i_compile_cmd(cmd[2]), .i_compile_done(done), .i_compile_ok(ok),
        .i_start_cmd(cmd[3]), .i_hold_cmd(cmd[4]), .i_resume_cmd(cmd[5]),
        .i_event_jump_command(cmd[6]), .i_stop_cmd(cmd[7]), .i_abort_now_command(cmd[8]),
        .i_edit_cmd(cmd[9]), .i_reset_cmd(cmd[10]), .i_store_cmd(cmd[11]),
        .i_cut_cmd(cmd[12]), .i_insert_cmd(cmd[13]), .i_copy_cmd(cmd[14]),
        .i_paste_cmd(cmd[15]), .i_channel_param_copy(cmd[16]),
        .i_channel_param_paste(cmd[17]), .i_edit_step(edit_step), .i_run_step(run_step),
        .i_run_step_event_en(ev_en), .i_event_dest(dest), .i_stop_wait_done(wdone),
        .o_state(o_state), .o_seq_mode(seqm), .o_executable(exe), .o_compile_req(creq),
        .o_compile_error(cerr), .o_run_enable(runen), .o_output_freeze(frz),
        .o_stop_req(sreq), .o_jump_req(jreq), .o_jump_dest(jdest), .o_out_step(ostep),
        .o_settings_reset(side_q[6]), .o_store_req(side_q[7]), .o_cut_req(side_q[5]),
        .o_insert_req(side_q[4]), .o_copy_req(side_q[3]), .o_copy_channel_only(side_q[2]),
        .o_paste_req(side_q[1]), .o_paste_channel_only(side_q[0]),
        .o_keep_dest_numbers(keep));
    seq_operator_model seq_operator_model_i (.i_clk(i_clk), .i_compile_req(creq),
        .i_stop_req(sreq), .i_fail(fail), .o_compile_done(done), .o_compile_ok(ok),
        .o_stop_wait_done(wdone));
    task pulse(input int k);
        @(negedge i_clk);
        cmd[k] = 1'b1;
        @(negedge i_clk);
        cmd = 18'h0_0000;
    endtask
    task chk(input logic [7:0] a, input logic [7:0] e);
        total_checks++;
        if (a !== e) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, a, e);
        end
    endtask
    task chs(input logic [2:0] e);
        chk({5'h00, o_state}, {5'h00, e});
    endtask
    task wait_st(input logic [2:0] e);
        for (int n = 0; n < 20 && o_state !== e; n++)
            @(negedge i_clk);
        chs(e);
    endtask
    task t_edit;
        pulse(0);
        chs(`ST_EDIT);
        chk(ostep, edit_step);
        chk({7'h00, seqm}, 8'h01);
        pulse(3);
        chk({4'h0, o_state, exe}, {4'h0, `ST_EDIT, 1'b0});
        fail = 1'b1;
        pulse(2);
        chs(`ST_COMPILE);
        wait_st(`ST_EDIT);
        chk({6'h00, cerr, exe}, 8'h02);
    endtask
    task t_freeze;
        @(negedge i_clk);
        i_ce = 1'b0;
        pulse(2);
        chk({4'h0, o_state, creq}, {4'h0, `ST_EDIT, 1'b0});
        @(negedge i_clk);
        i_ce = 1'b1;
    endtask
    task t_side;
        logic [7:0] exp [8] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h0C, 8'h06, 8'h07};
        int idx [8] = '{11, 10, 12, 13, 14, 16, 15, 17};
        for (int k = 0; k < 8; k++) begin
            pulse(idx[k]);
            chk(side_q, exp[k]);
        end
        chk({7'h00, keep}, 8'h01);
        edit_step = 8'h09;
        @(negedge i_clk);
        chk(ostep, 8'h09);
    endtask
    task t_run;
        fail = 1'b0;
        pulse(2);
        wait_st(`ST_READY);
        chk({ostep[5:0], cerr, exe}, 8'h01);
        pulse(11);
        chk({7'h00, side_q[7]}, 8'h00);
        pulse(3);
        chs(`ST_RUN);
        pulse(4);
        chk({5'h00, o_state}, {5'h00, `ST_HOLD});
        chk({6'h00, frz, runen}, 8'h02);
        chk(ostep, run_step);
        pulse(6);
        chk({7'h00, jreq}, 8'h00);
        ev_en = 1'b1;
        pulse(6);
        chk({jdest[6:0], jreq}, {dest[6:0], 1'b1});
        pulse(5);
        chs(`ST_RUN);
        pulse(7);
        chs(`ST_STOPPING);
        chk({6'h00, frz, runen}, 8'h01);
        pulse(6);
        chk({7'h00, jreq}, 8'h00);
        wait_st(`ST_READY);
        chk(ostep, 8'h00);
        pulse(3);
        pulse(8);
        chs(`ST_READY);
        pulse(3);
        pulse(7);
        pulse(8);
        chk({o_state, ostep[4:0]}, {`ST_READY, 5'h00});
        pulse(9);
        chs(`ST_EDIT);
        pulse(3);
        chs(`ST_EDIT);
        pulse(1);
        chs(`ST_OSC);
        chk({7'h00, seqm}, 8'h00);
    endtask
    task end_of_test;
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        forever #12.5 i_clk = ~i_clk;
    end
    initial begin
        #50000;
        bad_count++;
        end_of_test;
    end
    initial begin
        repeat (8) @(negedge i_clk);
        i_rst_n = 1'b1;
        t_edit;
        t_freeze;
        t_side;
        t_run;
        pulse(0);
        i_rst_n = 1'b0;
        #1;
        chs(`ST_OSC);
        chk({ostep[5:0], keep, exe}, 8'h02);
        @(negedge i_clk);
        i_rst_n = 1'b1;
        pulse(0);
        chs(`ST_EDIT);
        end_of_test;
    end
endmodule // tb

// *** verilog/seq_ctrl_defines.vh ***
// Constants for the sequence run controller
`ifndef SEQ_CTRL_DEFINES_VH
`define SEQ_CTRL_DEFINES_VH
`define ST_OSC 3'h0
`define ST_EDIT 3'h1
`define ST_COMPILE 3'h2
`define ST_READY 3'h3
`define ST_RUN 3'h4
`define ST_HOLD 3'h5
`define ST_STOPPING 3'h6
`define STEP_IDLE 8'h00
`define STEP_W 8
`define ERR_NONE 2'h0
`define ERR_COMPILE 2'h1
`endif

// *** verilog/sequence_run_controller.v ***
// Sequence run controller: command state machine for step-sequence oscillation
`timescale 1ns/100ps
// Function
// - Compile validates, allocates, ranges, then ready.
// - Failed compile reports error, stays editing.
// - Only successful compile makes sequence runnable.
// - Start in ready begins run.
// - Hold in run pauses, output unchanged.
// - Resume in hold continues the run.
// - Event jump only when step enables it.
// - Stop ends run, idle step, ready.
// - Abort-now ends at once, skips wait.
// - Edit in ready returns to editing.
// - Editing again needs a new compile.
// - Editing outputs the selected step.
// - Cut or insert keeps jump destinations.
// - Copy full or channel set, paste.
// - Reset restores all sequence settings.
// - Store only in editing; power loss clears.
// - Leaving sequence mode restores normal oscillation.
// - Entering sequence mode shows the selected edit step.
`include "seq_ctrl_defines.vh"
module sequence_run_controller #(
    parameter STEP_W = `STEP_W
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_ce,
    input wire i_enter_seq_mode,
    input wire i_leave_seq_mode,
    input wire i_compile_cmd,
    input wire i_compile_done,
    input wire i_compile_ok,
    input wire i_start_cmd,
    input wire i_hold_cmd,
    input wire i_resume_cmd,
    input wire i_event_jump_command,
    input wire i_stop_cmd,
    input wire i_abort_now_command,
    input wire i_edit_cmd,
    input wire i_reset_cmd,
    input wire i_store_cmd,
    input wire i_cut_cmd,
    input wire i_insert_cmd,
    input wire i_copy_cmd,
    input wire i_paste_cmd,
    input wire i_channel_param_copy,
    input wire i_channel_param_paste,
    input wire [STEP_W-1:0] i_edit_step,
    input wire [STEP_W-1:0] i_run_step,
    input wire i_run_step_event_en,
    input wire [STEP_W-1:0] i_event_dest,
    input wire i_stop_wait_done,
    output reg [2:0] o_state,
    output wire o_seq_mode,
    output wire o_executable,
    output reg o_compile_req,
    output reg o_compile_error,
    output reg o_run_enable,
    output reg o_output_freeze,
    output reg o_stop_req,
    output reg o_jump_req,
    output reg [STEP_W-1:0] o_jump_dest,
    output reg [STEP_W-1:0] o_out_step,
    output reg o_settings_reset,
    output reg o_store_req,
    output reg o_cut_req,
    output reg o_insert_req,
    output reg o_copy_req,
    output reg o_copy_channel_only,
    output reg o_paste_req,
    output reg o_paste_channel_only,
    output reg o_keep_dest_numbers
);
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg executable_reg;
    reg executable_next;

    function is_active;
        input [2:0] st;
        begin
            is_active = (st == `ST_RUN) || (st == `ST_HOLD);
        end
    endfunction

    assign o_seq_mode = (state_reg != `ST_OSC);
    assign o_executable = executable_reg;

    // Priority: leaving mode, then abort, stop, the rest; a single command per cycle expected
    always @* begin
        state_next = state_reg;
        executable_next = executable_reg;
        if (state_reg != `ST_OSC && i_leave_seq_mode) begin
            state_next = `ST_OSC;
            executable_next = 1'b0;
        end else begin
            case (state_reg)
                `ST_OSC: begin
                    if (i_enter_seq_mode) begin
                        state_next = `ST_EDIT;
                        executable_next = 1'b0;
                    end
                end
                `ST_EDIT: begin
                    if (i_compile_cmd) begin
                        state_next = `ST_COMPILE;
                    end else if (i_reset_cmd) begin
                        executable_next = 1'b0;
                    end
                end
                `ST_COMPILE: begin
                    if (i_compile_done) begin
                        state_next = i_compile_ok ? `ST_READY : `ST_EDIT;
                        executable_next = i_compile_ok;
                    end
                end
                `ST_READY: begin
                    if (i_start_cmd) begin
                        state_next = `ST_RUN;
                    end else if (i_edit_cmd) begin
                        state_next = `ST_EDIT;
                        executable_next = 1'b0;
                    end
                end
                `ST_RUN: begin
                    if (i_abort_now_command) begin
                        state_next = `ST_READY;
                    end else if (i_stop_cmd) begin
                        state_next = `ST_STOPPING;
                    end else if (i_hold_cmd) begin
                        state_next = `ST_HOLD;
                    end
                end
                `ST_HOLD: begin
                    if (i_abort_now_command) begin
                        state_next = `ST_READY;
                    end else if (i_stop_cmd) begin
                        state_next = `ST_STOPPING;
                    end else if (i_resume_cmd) begin
                        state_next = `ST_RUN;
                    end
                end
                `ST_STOPPING: begin
                    // Abort may still cut short a pending stop-phase wait or sweep
                    if (i_abort_now_command || i_stop_wait_done) begin
                        state_next = `ST_READY;
                    end
                end
                default: begin
                    state_next = `ST_OSC;
                    executable_next = 1'b0;
                end
            endcase
        end
    end

    // Leaving the mode outranks every other request taken in the same cycle
    wire in_edit = (state_reg == `ST_EDIT) && !i_leave_seq_mode;
    wire in_active = is_active(state_reg) && !i_leave_seq_mode;
    wire take_compile = in_edit && i_compile_cmd;
    wire compile_result = (state_reg == `ST_COMPILE) && !i_leave_seq_mode && i_compile_done;
    wire take_jump = in_active && (state_next == state_reg) && i_event_jump_command
        && i_run_step_event_en;
    wire take_stop = in_active && i_stop_cmd && !i_abort_now_command;
    wire take_copy = in_edit && (i_copy_cmd || i_channel_param_copy);
    wire take_paste = in_edit && (i_paste_cmd || i_channel_param_paste);

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // Power-off is the only clear of the working sequence
            state_reg <= `ST_OSC;
            executable_reg <= 1'b0;
            o_state <= `ST_OSC;
        end else if (i_ce) begin
            state_reg <= state_next;
            executable_reg <= executable_next;
            o_state <= state_next;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_compile_req <= 1'b0;
        end else if (i_ce) begin
            // One pulse to the compile engine per accepted command
            o_compile_req <= take_compile;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_compile_error <= 1'b0;
        end else if (i_ce) begin
            // Error stays visible until the operator compiles again
            if (compile_result) begin
                o_compile_error <= !i_compile_ok;
            end else if (take_compile) begin
                o_compile_error <= 1'b0;
            end
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_run_enable <= 1'b0;
            o_output_freeze <= 1'b0;
        end else if (i_ce) begin
            // Stopping still runs: the stop-phase wait or sweep plays out
            o_run_enable <= (state_next == `ST_RUN) || (state_next == `ST_STOPPING);
            o_output_freeze <= (state_next == `ST_HOLD);
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_stop_req <= 1'b0;
        end else if (i_ce) begin
            // Abort skips the stop phase, so no stop request goes out for it
            o_stop_req <= take_stop;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_jump_req <= 1'b0;
            o_jump_dest <= `STEP_IDLE;
        end else if (i_ce) begin
            // Jump only honoured when the executing step allows it
            o_jump_req <= take_jump;
            if (take_jump) begin
                o_jump_dest <= i_event_dest;
            end
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_out_step <= `STEP_IDLE;
        end else if (i_ce) begin
            // Idle step stands before start, at the end and outside the mode
            case (state_next)
                `ST_EDIT: o_out_step <= i_edit_step;
                `ST_RUN, `ST_HOLD, `ST_STOPPING: o_out_step <= i_run_step;
                default: o_out_step <= `STEP_IDLE;
            endcase
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_settings_reset <= 1'b0;
        end else if (i_ce) begin
            // Compile wins over reset so a half-cleared sequence is never compiled
            o_settings_reset <= in_edit && !i_compile_cmd && i_reset_cmd;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_store_req <= 1'b0;
            o_cut_req <= 1'b0;
            o_insert_req <= 1'b0;
        end else if (i_ce) begin
            // Storing is allowed only while editing, never while the sequence is executable
            o_store_req <= in_edit && i_store_cmd;
            o_cut_req <= in_edit && i_cut_cmd;
            o_insert_req <= in_edit && i_insert_cmd;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_keep_dest_numbers <= 1'b1;
        end else if (i_ce) begin
            // Destinations are stored as step numbers and never renumbered
            o_keep_dest_numbers <= 1'b1;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_copy_req <= 1'b0;
            o_copy_channel_only <= 1'b0;
        end else if (i_ce) begin
            // Qualifier holds until the next copy; full copy wins a tie
            o_copy_req <= take_copy;
            if (take_copy) begin
                o_copy_channel_only <= i_channel_param_copy && !i_copy_cmd;
            end
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_paste_req <= 1'b0;
            o_paste_channel_only <= 1'b0;
        end else if (i_ce) begin
            // Channel-only paste leaves the step control parameters alone
            o_paste_req <= take_paste;
            if (take_paste) begin
                o_paste_channel_only <= i_channel_param_paste && !i_paste_cmd;
            end
        end
    end
endmodule // sequence_run_controller
